//--- rtl/pmr_consts.svh
/*
  Shared constants of the power monitor register bank: pointer values,
  field positions, reset values and conversion timing figures.
  Assumes inclusion by bare name from rtl/ sources.
*/
`ifndef PMR_CONSTS_SVH
`define PMR_CONSTS_SVH

// ----------------------------------------------------------------------
// register pointers
// ----------------------------------------------------------------------
`define PMR_PTR_CFG   8'h00
`define PMR_PTR_SHUNT 8'h01
`define PMR_PTR_RAIL  8'h02
`define PMR_PTR_PWR   8'h03
`define PMR_PTR_CUR   8'h04
`define PMR_PTR_CAL   8'h05
`define PMR_PTR_MASK  8'h06
`define PMR_PTR_LIM   8'h07

// ----------------------------------------------------------------------
// config fields and reset values
// ----------------------------------------------------------------------
`define PMR_CFG_RST     16'h4127
`define PMR_CFG_WMASK   16'h0FFF
`define PMR_CFG_FIXED   16'h4000
`define PMR_REG_RST     16'h0000
`define PMR_RESET_BIT   15
`define PMR_MEAN_LSB    9
`define PMR_RAIL_LSB    6
`define PMR_SENSE_LSB   3
`define PMR_RDY_BIT     3

// ----------------------------------------------------------------------
// timing and arithmetic
// ----------------------------------------------------------------------
`define PMR_CLK_NS      5
`define PMR_CT0_NS      140000
`define PMR_CT1_NS      204000
`define PMR_CT2_NS      332000
`define PMR_CT3_NS      588000
`define PMR_CT4_NS      1100000
`define PMR_CT5_NS      2116000
`define PMR_CT6_NS      4156000
`define PMR_CT7_NS      8244000
`define PMR_CUR_SHIFT   11
`define PMR_PWR_SHIFT   12

`endif

//--- rtl/pmr_pkg.sv
/*
  Types of the power monitor register bank.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pmr_pkg;
  // conversion sequencer, gray along idle-shunt-rail-publish
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHUNT = 2'b01,
    ST_RAIL  = 2'b11,
    ST_PUB   = 2'b10
  } pmr_state_type;
  typedef logic [15:0] pmr_word_type;
endpackage

//--- rtl/pmr_conv_timer.sv
/*
  Down counter timing one conversion phase; pulses done at the end.
  Assumes a period of at least one cycle on load.
*/
`timescale 1ns/1ps
`default_nettype none
module pmr_conv_timer #(
  parameter int unsigned W = 21
) (
  // clock, reset, enable
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  input  wire logic         ce_in,
  // control
  input  wire logic         load_in,
  input  wire logic         clear_in,
  input  wire logic [W-1:0] period_in,
  // status
  output logic              done_out
);
  logic [W-1:0] cnt_q, cnt_d;
  logic         done_q, done_d;

  // ----------------------------------------------------------------------
  // count down, clear wins over load
  // ----------------------------------------------------------------------
  always_comb begin
    cnt_d  = cnt_q;
    done_d = 1'b0;
    if (clear_in) begin
      cnt_d = '0;
    end else if (load_in) begin
      cnt_d = period_in;
    end else if (cnt_q != '0) begin
      cnt_d  = cnt_q - 1'b1;
      done_d = (cnt_q == W'(1));
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end else if (ce_in) begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  assign done_out = done_q;
endmodule
`default_nettype wire

//--- rtl/pmr_result_calc.sv
/*
  Current and power arithmetic from mean shunt drop, rail and scale factor.
  Assumes the caller registers the outputs; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pmr_consts.svh"
module pmr_result_calc
  import pmr_pkg::*;
(
  // inputs
  input  wire logic [15:0] shunt_in,
  input  wire logic [15:0] rail_in,
  input  wire logic [15:0] scale_in,
  // results
  output pmr_word_type     cur_out,
  output pmr_word_type     pwr_out
);
  logic signed [32:0] cur_prod;
  logic signed [32:0] cur_sh;
  logic signed [32:0] pwr_prod;
  logic signed [32:0] pwr_sh;

  // shunt is two's complement; scale and rail are magnitudes
  always_comb begin
    // both factors widened first so the product is never formed at 17 bits
    cur_prod = 33'($signed(shunt_in)) * 33'($signed({1'b0, scale_in}));
    cur_sh   = cur_prod >>> `PMR_CUR_SHIFT;
    pwr_prod = 33'($signed(cur_sh[15:0])) * 33'($signed({1'b0, rail_in}));
    pwr_sh   = pwr_prod >>> `PMR_PWR_SHIFT;
    // explicit gate so a zero scale never leaks rounding residue
    if (scale_in == 16'h0000) begin
      cur_out = '0;
      pwr_out = '0;
    end else begin
      cur_out = cur_sh[15:0];
      pwr_out = pwr_sh[15:0];
    end
  end
endmodule
`default_nettype wire

//--- rtl/pmr_regbank.sv
/*
  Register bank of a shunt current and power monitor, with the conversion
  sequencer it steers. Faces a serial slave engine through byte strobes.
  Assumes the engine decodes addressing and gives one-cycle strobes.
*/
// Summary of operation
// - every register is 16 bits, moved as two bytes, high byte first
// - config at pointer 0, read/write, resets to 4127h
// - pointers 1 to 4 hold read-only results, reset zero
// - scale factor at pointer 5 resets zero; zero forces current and power zero
// - alert mask at pointer 6, read/write, holds conversion-ready flag
// - alert threshold at pointer 7, read/write, resets zero
// - reading config never disturbs settings or a running conversion
// - config write halts conversion until write ends, then restarts fresh
// - writing config bit 15 resets every register; bit reads zero
// - bits 11:9 pick 1,4,16,64,128,256,512 or 1024 samples averaged
// - bits 8:6 pick rail conversion time, 140 us to 8.244 ms
// - bits 5:3 pick shunt conversion time independently
// - bits 2:0 pick power-down, triggered or continuous shunt/rail/both
// - shunt result is signed two's complement, 2.5 uV per count
`timescale 1ns/1ps
`default_nettype none
`include "pmr_consts.svh"
module pmr_regbank
  import pmr_pkg::*;
#(
  parameter int unsigned CONV_NS [8] = '{`PMR_CT0_NS, `PMR_CT1_NS, `PMR_CT2_NS,
    `PMR_CT3_NS, `PMR_CT4_NS, `PMR_CT5_NS, `PMR_CT6_NS, `PMR_CT7_NS}
) (
  // clock, reset, enable
  input  wire logic        core_clk_in,
  input  wire logic        nrst_in,
  input  wire logic        ce_in,
  // byte port from the serial engine
  input  wire logic        ptr_wr_in,
  input  wire logic        byte_wr_in,
  input  wire logic        byte_rd_in,
  input  wire logic        xfer_end_in,
  input  wire logic [7:0]  data_in,
  // converter samples
  input  wire logic [15:0] shunt_sample_in,
  input  wire logic [15:0] rail_sample_in,
  // outputs
  output logic [7:0]       rd_byte_out,
  output logic [15:0]      cfg_word_out,
  output logic [15:0]      mask_word_out,
  output logic [15:0]      limit_word_out,
  output logic             conv_active_out,
  output logic             rail_sel_out
);
  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic [7:0]    ptr_q, ptr_d, msb_q, msb_d, lsb_q, lsb_d, rd_q, rd_d;
  logic          phase_q, phase_d, hold_q, hold_d;
  logic          restart_q, restart_d, soft_q, soft_d;
  pmr_word_type  cfg_q, cfg_d, cal_q, cal_d, mask_q, mask_d, lim_q, lim_d;
  pmr_word_type  wdata, rmux;
  pmr_state_type state_q, state_d;
  logic          go_q, go_d, act_q, sel_q;
  logic [10:0]   cnt_q, cnt_d, last_cnt;
  logic signed [25:0] acc_sh_q, acc_sh_d, acc_rl_q, acc_rl_d;
  logic signed [25:0] sh_div, rl_div;
  pmr_word_type  shunt_q, shunt_d, rail_q, rail_d, cur_q, cur_d, pwr_q, pwr_d;
  pmr_word_type  calc_sh, calc_rl, calc_cur, calc_pwr;
  logic [3:0]    mean_shift;
  logic [2:0]    sample_mean_count, rail_sample_period, sense_drop_sample_period;
  logic          op_select_bit2, op_select_bit1, op_select_bit0;
  logic          tmr_load, tmr_done, pub;
  logic [20:0]   tmr_per;
  logic [20:0]   per_cyc [8];

  // ----------------------------------------------------------------------
  // config fields and cycle table
  // ----------------------------------------------------------------------
  assign sample_mean_count        = cfg_q[`PMR_MEAN_LSB +: 3];
  assign rail_sample_period       = cfg_q[`PMR_RAIL_LSB +: 3];
  assign sense_drop_sample_period = cfg_q[`PMR_SENSE_LSB +: 3];
  assign op_select_bit2           = cfg_q[2];
  assign op_select_bit1           = cfg_q[1];
  assign op_select_bit0           = cfg_q[0];
  assign pub                      = (state_q == ST_PUB);

  // each conversion time rounded down to whole cycles
  for (genvar i = 0; i < 8; i++) begin : g_per
    assign per_cyc[i] = 21'(CONV_NS[i] / `PMR_CLK_NS);
  end

  // ----------------------------------------------------------------------
  // read multiplexer
  // ----------------------------------------------------------------------
  always_comb begin
    case (ptr_q)
      `PMR_PTR_CFG:   rmux = cfg_q;
      `PMR_PTR_SHUNT: rmux = shunt_q;
      `PMR_PTR_RAIL:  rmux = rail_q;
      // stale results are masked as soon as the scale factor goes to zero
      `PMR_PTR_PWR:   rmux = (cal_q == 16'h0000) ? 16'h0000 : pwr_q;
      `PMR_PTR_CUR:   rmux = (cal_q == 16'h0000) ? 16'h0000 : cur_q;
      `PMR_PTR_CAL:   rmux = cal_q;
      `PMR_PTR_MASK:  rmux = mask_q;
      `PMR_PTR_LIM:   rmux = lim_q;
      default:        rmux = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------------
  // register bank next state
  // ----------------------------------------------------------------------
  always_comb begin
    ptr_d = ptr_q;  phase_d = phase_q;  msb_d = msb_q;  lsb_d = lsb_q;
    rd_d = rd_q;  cfg_d = cfg_q;  cal_d = cal_q;  mask_d = mask_q;
    lim_d = lim_q;  hold_d = hold_q;  restart_d = 1'b0;  soft_d = 1'b0;
    wdata = {msb_q, data_in};
    if (soft_q) begin
      // same values as power-on; the reset bit itself is never stored
      ptr_d = 8'h00;  phase_d = 1'b0;  msb_d = 8'h00;  lsb_d = 8'h00;
      rd_d = 8'h00;  cfg_d = `PMR_CFG_RST;  cal_d = `PMR_REG_RST;
      mask_d = `PMR_REG_RST;  lim_d = `PMR_REG_RST;  hold_d = 1'b0;
    end else begin
      if (ptr_wr_in) begin
        ptr_d   = data_in;
        phase_d = 1'b0;
      end else if (byte_wr_in) begin
        if (!phase_q) begin
          msb_d   = data_in;
          phase_d = 1'b1;
          if (ptr_q == `PMR_PTR_CFG) hold_d = 1'b1;
        end else begin
          phase_d = 1'b0;
          case (ptr_q)
            `PMR_PTR_CFG: begin
              if (wdata[`PMR_RESET_BIT]) soft_d = 1'b1;
              else cfg_d = (wdata & `PMR_CFG_WMASK) | `PMR_CFG_FIXED;
            end
            `PMR_PTR_CAL:  cal_d = wdata;
            `PMR_PTR_MASK: begin
              mask_d = wdata;
              mask_d[`PMR_RDY_BIT] = mask_q[`PMR_RDY_BIT];
            end
            `PMR_PTR_LIM:  lim_d = wdata;
            default:       ;  // results and unmapped pointers ignore writes
          endcase
        end
      end else if (byte_rd_in) begin
        if (!phase_q) begin
          // snapshot the word so the low byte matches the high byte
          rd_d    = rmux[15:8];
          lsb_d   = rmux[7:0];
          phase_d = 1'b1;
          if (ptr_q == `PMR_PTR_MASK) mask_d[`PMR_RDY_BIT] = 1'b0;
        end else begin
          rd_d    = lsb_q;
          phase_d = 1'b0;
        end
      end
      if (xfer_end_in) begin
        phase_d = 1'b0;  // an odd byte is dropped
        if (hold_q) begin
          hold_d    = 1'b0;
          restart_d = 1'b1;
        end
      end
      // a new result beats a read-clear in the same cycle
      if (pub) mask_d[`PMR_RDY_BIT] = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ptr_q <= 8'h00;  phase_q <= 1'b0;  msb_q <= 8'h00;  lsb_q <= 8'h00;
      rd_q <= 8'h00;  cfg_q <= `PMR_CFG_RST;  cal_q <= `PMR_REG_RST;
      mask_q <= `PMR_REG_RST;  lim_q <= `PMR_REG_RST;
      hold_q <= 1'b0;  restart_q <= 1'b0;  soft_q <= 1'b0;
    end else if (ce_in) begin
      ptr_q <= ptr_d;  phase_q <= phase_d;  msb_q <= msb_d;  lsb_q <= lsb_d;
      rd_q <= rd_d;  cfg_q <= cfg_d;  cal_q <= cal_d;  mask_q <= mask_d;
      lim_q <= lim_d;  hold_q <= hold_d;  restart_q <= restart_d;  soft_q <= soft_d;
    end
  end

  // ----------------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------------
  // sample counts 1,4,16,64 then 128..1024 as shifts 0,2,4,6,7,8,9,10
  always_comb begin
    if (sample_mean_count < 3'd4) mean_shift = {sample_mean_count, 1'b0};
    else mean_shift = {1'b0, sample_mean_count} + 4'd3;
    last_cnt = 11'((12'd1 << mean_shift) - 12'd1);
    sh_div   = acc_sh_q >>> mean_shift;
    rl_div   = acc_rl_q >>> mean_shift;
    calc_sh  = op_select_bit0 ? sh_div[15:0] : shunt_q;
    calc_rl  = op_select_bit1 ? rl_div[15:0] : rail_q;
  end

  always_comb begin
    state_d = state_q;  go_d = go_q;  cnt_d = cnt_q;  acc_sh_d = acc_sh_q;
    acc_rl_d = acc_rl_q;  shunt_d = shunt_q;  rail_d = rail_q;
    cur_d = cur_q;  pwr_d = pwr_q;  tmr_load = 1'b0;
    tmr_per = op_select_bit0 ? per_cyc[sense_drop_sample_period] : per_cyc[rail_sample_period];
    if (soft_q) begin
      state_d = ST_IDLE;  go_d = 1'b1;  cnt_d = '0;  acc_sh_d = '0;  acc_rl_d = '0;
      shunt_d = `PMR_REG_RST;  rail_d = `PMR_REG_RST;
      cur_d = `PMR_REG_RST;  pwr_d = `PMR_REG_RST;
    end else if (hold_q) begin
      // partial sums are discarded so the next result uses new settings
      state_d = ST_IDLE;  cnt_d = '0;  acc_sh_d = '0;  acc_rl_d = '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          go_d = go_q | restart_q;
          if (go_d) begin
            go_d = 1'b0;
            if (op_select_bit0 | op_select_bit1) begin
              tmr_load = 1'b1;
              state_d  = op_select_bit0 ? ST_SHUNT : ST_RAIL;
            end
          end
        end
        ST_SHUNT: begin
          if (tmr_done) begin
            acc_sh_d = acc_sh_q + 26'($signed(shunt_sample_in));
            tmr_load = 1'b1;
            tmr_per  = per_cyc[rail_sample_period];
            if (op_select_bit1) state_d = ST_RAIL;
            else if (cnt_q == last_cnt) begin
              tmr_load = 1'b0;
              state_d  = ST_PUB;
            end else begin
              cnt_d   = cnt_q + 11'd1;
              tmr_per = per_cyc[sense_drop_sample_period];
            end
          end
        end
        ST_RAIL: begin
          if (tmr_done) begin
            acc_rl_d = acc_rl_q + $signed({10'd0, rail_sample_in});
            if (cnt_q == last_cnt) state_d = ST_PUB;
            else begin
              cnt_d    = cnt_q + 11'd1;
              tmr_load = 1'b1;
              state_d  = op_select_bit0 ? ST_SHUNT : ST_RAIL;
            end
          end
        end
        ST_PUB: begin
          shunt_d  = calc_sh;
          rail_d   = calc_rl;
          cur_d    = calc_cur;
          pwr_d    = calc_pwr;
          cnt_d    = '0;  acc_sh_d = '0;  acc_rl_d = '0;
          // triggered modes stop here; continuous ones go again at once
          if (op_select_bit2) begin
            tmr_load = 1'b1;
            state_d  = op_select_bit0 ? ST_SHUNT : ST_RAIL;
          end else state_d = ST_IDLE;
        end
        default: state_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= ST_IDLE;  go_q <= 1'b1;  cnt_q <= '0;  acc_sh_q <= '0;
      acc_rl_q <= '0;  shunt_q <= `PMR_REG_RST;  rail_q <= `PMR_REG_RST;
      cur_q <= `PMR_REG_RST;  pwr_q <= `PMR_REG_RST;  act_q <= 1'b0;  sel_q <= 1'b0;
    end else if (ce_in) begin
      state_q <= state_d;  go_q <= go_d;  cnt_q <= cnt_d;  acc_sh_q <= acc_sh_d;
      acc_rl_q <= acc_rl_d;  shunt_q <= shunt_d;  rail_q <= rail_d;
      cur_q <= cur_d;  pwr_q <= pwr_d;
      act_q <= (state_d != ST_IDLE);
      sel_q <= (state_d == ST_RAIL);
    end
  end

  // ----------------------------------------------------------------------
  // helpers and outputs
  // ----------------------------------------------------------------------
  pmr_conv_timer #(.W(21)) u_timer (
    .clk_in   (core_clk_in),
    .nrst_in  (nrst_in),
    .ce_in    (ce_in),
    .load_in  (tmr_load),
    .clear_in (hold_q | soft_q),
    .period_in(tmr_per),
    .done_out (tmr_done)
  );

  pmr_result_calc u_calc (
    .shunt_in(calc_sh),
    .rail_in (calc_rl),
    .scale_in(cal_q),
    .cur_out (calc_cur),
    .pwr_out (calc_pwr)
  );

  assign rd_byte_out     = rd_q;
  assign cfg_word_out    = cfg_q;
  assign mask_word_out   = mask_q;
  assign limit_word_out  = lim_q;
  assign conv_active_out = act_q;
  assign rail_sel_out    = sel_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  chk_soft_defaults: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (ce_in && soft_q) |=> (cfg_q == `PMR_CFG_RST && cal_q == 16'h0000 && lim_q == 16'h0000))
    else $error("soft reset did not restore defaults");
  chk_ro_results: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (ce_in && byte_wr_in && phase_q && !ptr_wr_in && !soft_q && !pub && ptr_q >= 8'h01
     && ptr_q <= 8'h04) |=> ($stable(shunt_q) && $stable(rail_q) && $stable(cur_q)))
    else $error("result register changed by a write");
  chk_cal_zero: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (ce_in && byte_rd_in && !ptr_wr_in && !byte_wr_in && !phase_q && !soft_q
     && cal_q == 16'h0000 && (ptr_q == 8'h03 || ptr_q == 8'h04))
    |=> (rd_q == 8'h00 && lsb_q == 8'h00))
    else $error("current or power nonzero with zero scale");
  chk_bad_ptr: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (ce_in && byte_rd_in && !ptr_wr_in && !byte_wr_in && !phase_q && !soft_q
     && ptr_q > 8'h07) |=> (rd_q == 8'h00))
    else $error("unmapped pointer read nonzero");
  chk_msb_first: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (ce_in && byte_rd_in && !ptr_wr_in && !byte_wr_in && !phase_q && !soft_q)
    |=> (rd_q == $past(rmux[15:8]) && lsb_q == $past(rmux[7:0]) && phase_q))
    else $error("read did not give high byte first");
  chk_cfg_write: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (ce_in && byte_wr_in && phase_q && !ptr_wr_in && !soft_q && ptr_q == 8'h00 && !msb_q[7])
    |=> (cfg_q == ((16'($past({msb_q, data_in})) & `PMR_CFG_WMASK) | `PMR_CFG_FIXED)))
    else $error("config write stored wrong value");
  chk_lim_write: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (ce_in && byte_wr_in && phase_q && !ptr_wr_in && !soft_q && ptr_q == 8'h07)
    |=> (lim_q == $past({msb_q, data_in})))
    else $error("threshold write lost");
  chk_rdy_set: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (ce_in && pub && !soft_q) |=> mask_q[`PMR_RDY_BIT])
    else $error("ready flag not set on publish");
  chk_read_quiet: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (ce_in && byte_rd_in && !ptr_wr_in && !byte_wr_in && !xfer_end_in && !soft_q)
    |=> ($stable(cfg_q) && $stable(hold_q)))
    else $error("read disturbed config or conversion");
  chk_hold_idle: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (ce_in && hold_q) |=> (state_q == ST_IDLE))
    else $error("conversion ran during config write");
  chk_restart_go: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (ce_in && restart_q && !hold_q && !soft_q && state_q == ST_IDLE && cfg_q[1:0] != 2'b00)
    |=> (state_q != ST_IDLE))
    else $error("no fresh conversion after config write");
  chk_mean_count: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (state_q == ST_SHUNT || state_q == ST_RAIL) |-> (cnt_q <= last_cnt))
    else $error("sample count beyond selected mean");
endmodule
`default_nettype wire

//--- tb/pmr_host_model.sv
/*
  Host side model: serial engine strobes for pointer set, word write, word read.
  Assumes the bench calls one task at a time after reset is released.
*/
`timescale 1ns/1ps
`default_nettype none
module pmr_host_model
  import pmr_pkg::*;
(
  // clock and read data
  input  wire logic       core_clk_in,
  input  wire logic [7:0] rd_byte_in,
  // byte port strobes and data
  output logic            ptr_wr_out,
  output logic            byte_wr_out,
  output logic            byte_rd_out,
  output logic            xfer_end_out,
  output logic      [7:0] data_out
);
  // ----------------------------------------------------------------
  // transfers, all driven at the falling edge
  // ----------------------------------------------------------------
  initial begin
    {ptr_wr_out, byte_wr_out, byte_rd_out, xfer_end_out} = 4'h0;
    data_out = 8'h00;
  end
  // pointer byte; strobe drops one cycle later
  task automatic set_ptr(input logic [7:0] p);
    @(negedge core_clk_in);
    ptr_wr_out = 1'b1;
    data_out   = p;
    @(negedge core_clk_in);
    ptr_wr_out = 1'b0;
  endtask
  // released bus shows the inverse of its last byte, never a stale copy
  task automatic wr_reg(input logic [7:0] p, input pmr_word_type w);
    set_ptr(p);
    byte_wr_out = 1'b1;
    data_out    = w[15:8];
    @(negedge core_clk_in);
    data_out = w[7:0];
    @(negedge core_clk_in);
    byte_wr_out  = 1'b0;
    xfer_end_out = 1'b1;
    data_out     = ~w[7:0];
    @(negedge core_clk_in);
    xfer_end_out = 1'b0;
  endtask
  // each byte is taken one cycle after its strobe, high byte first
  task automatic rd_reg(input logic [7:0] p, output pmr_word_type w);
    set_ptr(p);
    data_out    = ~p;
    byte_rd_out = 1'b1;
    @(negedge core_clk_in);
    w[15:8] = rd_byte_in;
    @(negedge core_clk_in);
    w[7:0]       = rd_byte_in;
    byte_rd_out  = 1'b0;
    xfer_end_out = 1'b1;
    @(negedge core_clk_in);
    xfer_end_out = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- tb/pmr_regbank_tb_top.sv
/*
  Self-checking bench of the register bank: word reads and writes through
  the host model, compared against the register table.
  Assumes the host model in tb/ and the package in rtl/.
*/
`timescale 1ns/1ps
`default_nettype none
module pmr_regbank_tb_top
  import pmr_pkg::*;
;
  logic         core_clk, nrst, ptr_wr, byte_wr, byte_rd, xfer_end, conv_active;
  logic         ce, rail_sel;
  logic [7:0]   data, rd_byte;
  pmr_word_type shunt, rail, cfg, mask, limit, w;
  pmr_word_type tbl [8] = '{16'h4127, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                            16'h0800, 16'ha5f0, 16'h1234};
  int           miscompares = 0;
  int           tests_run = 0;
  // ----------------------------------------------------------------
  // design and host; code 4 is long so power-on reads beat the first result
  // ----------------------------------------------------------------
  pmr_regbank #(.CONV_NS('{100, 100, 100, 100, 20000, 100, 100, 100})) pmr_regbank_inst (
    .core_clk_in(core_clk), .nrst_in(nrst), .ce_in(ce), .ptr_wr_in(ptr_wr),
    .byte_wr_in(byte_wr), .byte_rd_in(byte_rd), .xfer_end_in(xfer_end), .data_in(data),
    .shunt_sample_in(shunt), .rail_sample_in(rail), .rd_byte_out(rd_byte),
    .cfg_word_out(cfg), .mask_word_out(mask), .limit_word_out(limit),
    .conv_active_out(conv_active), .rail_sel_out(rail_sel));
  pmr_host_model pmr_host_model_inst (.core_clk_in(core_clk), .rd_byte_in(rd_byte),
    .ptr_wr_out(ptr_wr), .byte_wr_out(byte_wr), .byte_rd_out(byte_rd),
    .xfer_end_out(xfer_end), .data_out(data));
  // compare one word
  task automatic chk(input string what, input pmr_word_type exp, input pmr_word_type got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd_chk(input logic [7:0] p, input pmr_word_type exp);
    pmr_host_model_inst.rd_reg(p, w);
    chk($sformatf("reg %0h", p), exp, w);
  endtask
  // bounded wait for a triggered conversion to finish
  task automatic wait_idle();
    repeat (10) @(negedge core_clk);
    for (int k = 0; k < 400 && conv_active === 1'b1; k++) @(negedge core_clk);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // whole run is a few hundred cycles
  initial begin
    #100000;
    miscompares++;
    end_sim();
  end
  initial begin
    nrst  = 1'b0;
    ce    = 1'b1;
    shunt = 16'h8300;
    rail  = 16'h1000;
    repeat (16) @(negedge core_clk);
    nrst = 1'b1;
    rd_chk(8'h00, 16'h4127);
    for (int i = 1; i < 9; i++) begin
      rd_chk(i[7:0], 16'h0000);
    end
    for (int i = 1; i < 9; i++) begin
      w = (i < 5 || i == 8) ? 16'hffff : tbl[i];
      pmr_host_model_inst.wr_reg(i[7:0], w);
    end
    for (int i = 1; i < 8; i++) rd_chk(i[7:0], tbl[i]);
    rd_chk(8'h08, 16'h0000);
    chk("mask port", 16'ha5f0, mask);
    chk("limit port", 16'h1234, limit);
    // with the enable low a whole write sequence must leave no trace
    ce = 1'b0;
    pmr_host_model_inst.wr_reg(8'h07, 16'h5555);
    ce = 1'b1;
    chk("frozen limit", 16'h1234, limit);
    pmr_host_model_inst.wr_reg(8'h00, 16'h7fff);
    rd_chk(8'h00, 16'h4fff);
    pmr_host_model_inst.wr_reg(8'h00, 16'h0003);
    chk("cfg port", 16'h4003, cfg);
    wait_idle();
    rd_chk(8'h01, 16'h8300);
    rd_chk(8'h02, 16'h1000);
    rd_chk(8'h04, 16'h8300);
    rd_chk(8'h03, 16'h8300);
    rd_chk(8'h06, 16'ha5f8);
    rd_chk(8'h06, 16'ha5f0);
    pmr_host_model_inst.wr_reg(8'h05, 16'h0000);
    rd_chk(8'h04, 16'h0000);
    rd_chk(8'h03, 16'h0000);
    // config read mid-conversion must not stop the fresh run
    pmr_host_model_inst.wr_reg(8'h00, 16'h0003);
    rd_chk(8'h00, 16'h4003);
    wait_idle();
    rd_chk(8'h06, 16'ha5f8);
    // rail-only triggered run: the shunt result keeps its old value
    rail = 16'h0abc;
    pmr_host_model_inst.wr_reg(8'h00, 16'h0002);
    @(negedge core_clk);
    chk("busy", 16'h0001, {15'h0000, conv_active});
    chk("rail sel", 16'h0001, {15'h0000, rail_sel});
    wait_idle();
    chk("busy", 16'h0000, {15'h0000, conv_active});
    rd_chk(8'h02, 16'h0abc);
    rd_chk(8'h01, 16'h8300);
    rd_chk(8'h06, 16'ha5f8);
    // power-down code with bit 2 set must not start a conversion
    pmr_host_model_inst.wr_reg(8'h00, 16'h0004);
    repeat (8) @(negedge core_clk);
    chk("busy", 16'h0000, {15'h0000, conv_active});
    rd_chk(8'h06, 16'ha5f0);
    pmr_host_model_inst.wr_reg(8'h00, 16'h8000);
    repeat (4) @(negedge core_clk);
    chk("cfg port", 16'h4127, cfg);
    rd_chk(8'h07, 16'h0000);
    rd_chk(8'h00, 16'h4127);
    rd_chk(8'h06, 16'h0000);
    end_sim();
  end
endmodule
`default_nettype wire
